/* hdl/spi_master_slave_port.sv */
// serial peripheral port, master or slave, with receive stream fifo
//
// Notes on behaviour
// - shift out and shift in together, both timed by one serial clock
// - unselected slave keeps its lines released and ignores bus activity
// - leading-edge sampling: msb ready before first edge, select fall starts
// - trailing-edge sampling: first clock edge drives data and starts transfer
// - master with select enabled sets mode fault when select is low
// - mode fault clears port enable and master select
// - select disabled gives no mode fault request; select is then free
// - mode fault cleared by status read with flag then control write
// - data write during a transfer sets write collision
// - write collision raises no request and leaves the transfer intact
// - write collision cleared by status access then data access
// - while done flag is set, buffer keeps first byte; later ones dropped
// - overrun is never detected or flagged
// - slave sets select error when select rises mid-byte
// - select error has no request; cleared only by writing enable 0
// - finished byte sets done flag, which drives transmit request
// - mode fault drives error request only while select is enabled
// - bytes go msb first on both data lines
// - master clock is core clock over 2 to 128; all-ones code unused
// - serial clock idles at the polarity setting
// - phase clear samples leaving idle; phase set samples returning
`timescale 1ns/1ns
`default_nettype none

module spi_master_slave_port
    import spi_port_pkg::*;
(
    // clock and reset
    input  wire logic                          core_clk_i,
    input  wire logic                          rst_i,
    // processor side: control register
    input  wire logic                          ctrl_wr_i,
    input  wire spi_port_pkg::port_control_t   ctrl_wdata_i,
    output spi_port_pkg::port_control_t        ctrl_o,
    // processor side: status register
    input  wire logic                          status_rd_i,
    output spi_port_pkg::port_status_t         status_o,
    // processor side: data register
    input  wire logic                          data_wr_i,
    input  wire logic                          data_rd_i,
    input  wire logic [7:0]                    data_wdata_i,
    output logic [7:0]                         data_o,
    // interrupt requests
    output logic                               tx_irq_o,
    output logic                               err_irq_o,
    // received byte stream
    output logic                               rx_valid_o,
    input  wire logic                          rx_ready_i,
    output logic [7:0]                         rx_data_o,
    // serial pins
    input  wire spi_port_pkg::pin_bits_t       pin_i,
    output spi_port_pkg::pin_bits_t            pin_o,
    output spi_port_pkg::pin_bits_t            pin_oe_o,
    input  wire logic                          ss_n_i
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    port_control_t  ctrl_q;
    port_control_t  ctrl_d;
    port_status_t   stat_q;
    port_status_t   stat_d;
    master_state_t  mst_q;
    master_state_t  mst_d;
    pin_bits_t      pin_s1_q;
    pin_bits_t      pin_s2_q;
    logic           sck_prev_q;
    logic           ss_s1_q;
    logic           ss_s2_q;
    logic           ss_prev_q;
    logic [7:0]     sh_q;
    logic [7:0]     rbuf_q;
    logic           out_q;
    logic           sck_q;
    logic [2:0]     bits_q;
    logic [3:0]     edge_q;
    logic [DIV_W-1:0] div_q;
    logic           arm_done_q;
    logic           arm_coll_q;
    logic           arm_fault_q;
    logic           tx_irq_q;
    logic           err_irq_q;
    pin_bits_t      pin_out_q;
    pin_bits_t      pin_oe_q;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire        enabled   = ctrl_q.port_enable_bit;
    wire        is_master = enabled && ctrl_q.master_select_bit;
    wire        is_slave  = enabled && !ctrl_q.master_select_bit;
    wire        cpol      = ctrl_q.clk_polarity;
    wire        cpha      = ctrl_q.clk_phase;
    wire [2:0]  rate      = {ctrl_q.rate_sel_bit2, ctrl_q.rate_sel_bit1,
                             ctrl_q.rate_sel_bit0};
    wire        data_acc  = data_wr_i || data_rd_i;
    wire        ss_low    = !ss_s2_q;
    wire        ss_rise   = ss_s2_q && !ss_prev_q;
    wire        ss_fall   = !ss_s2_q && ss_prev_q;

    // phase set with select disabled keeps the slave selected
    wire        slv_sel   = ss_low ||
                            (ctrl_q.select_disable_bit && cpha);
    wire        slv_on    = is_slave && slv_sel;

    // half period of 2**rate core cycles, no clock for code 7
    wire [DIV_W-1:0] half = (DIV_ONE << rate) - DIV_ONE;
    wire        tick      = (mst_q == M_SHIFT) && (rate != RATE_NONE) &&
                            (div_q == half);

    // slave edge detect relative to the idle level
    wire        s_lead    = (sck_prev_q == cpol) &&
                            (pin_s2_q.sck != cpol);
    wire        s_trail   = (sck_prev_q != cpol) &&
                            (pin_s2_q.sck == cpol);
    wire        m_lead    = tick && !edge_q[0];
    wire        m_trail   = tick && edge_q[0];
    wire        lead_ev   = is_master ? m_lead : (slv_on && s_lead);
    wire        trail_ev  = is_master ? m_trail : (slv_on && s_trail);

    // phase picks the sampling edge, the other edge drives
    wire        samp_ev   = cpha ? trail_ev : lead_ev;
    wire        drive_ev  = cpha ? lead_ev : trail_ev;
    wire        in_bit    = is_master ? pin_s2_q.miso : pin_s2_q.mosi;

    wire        m_done    = m_trail && (edge_q == EDGE_LAST);
    wire        s_done    = slv_on && samp_ev && (bits_q == BIT_LAST);
    wire        done_ev   = m_done || s_done;
    wire [7:0]  rx_byte   = {sh_q[6:0], in_bit};
    // master with phase clear ends on a drive edge: the byte already sits in sh_q
    wire [7:0]  done_byte = samp_ev ? rx_byte : sh_q;

    // transfer in progress for collision purposes
    wire        busy      = is_master ? (mst_q != M_IDLE)
                                      : (bits_q != 3'h0);

    wire        collide   = data_wr_i && enabled && busy;
    wire        load      = data_wr_i && !collide;

    // master with select enabled faults on a low select
    wire        fault_ev  = is_master && !ctrl_q.select_disable_bit &&
                            ss_low;

    // select rises while a slave byte is partly received
    wire        sel_err   = is_slave && ss_rise && (bits_q != 3'h0);

    wire        fifo_ready;
    wire        fifo_push = done_ev && fifo_ready;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pin_s1_q   <= '0;
            pin_s2_q   <= '0;
            sck_prev_q <= 1'b0;
            ss_s1_q    <= 1'b1;
            ss_s2_q    <= 1'b1;
            ss_prev_q  <= 1'b1;
        end else begin
            pin_s1_q   <= pin_i;
            pin_s2_q   <= pin_s1_q;
            sck_prev_q <= pin_s2_q.sck;
            ss_s1_q    <= ss_n_i;
            ss_s2_q    <= ss_s1_q;
            ss_prev_q  <= ss_s2_q;
        end
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        if (ctrl_wr_i) begin
            ctrl_d = ctrl_wdata_i;
        end
        // fault drops enable and master select
        if (fault_ev) begin
            ctrl_d.port_enable_bit   = 1'b0;
            ctrl_d.master_select_bit = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ctrl_q <= port_control_t'(CTRL_RESET);
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ------------------------------------------------------------
    // status flags and clearing sequences
    // ------------------------------------------------------------
    always_comb begin
        stat_d = stat_q;
        // status read with flag set, then data access
        if (arm_done_q && data_acc) begin
            stat_d.transfer_done_flag = 1'b0;
        end
        if (arm_coll_q && data_acc) begin
            stat_d.write_collision_flag = 1'b0;
        end
        // status read with flag set, then control write
        if (arm_fault_q && ctrl_wr_i) begin
            stat_d.mode_fault_flag = 1'b0;
        end
        // only a write of enable 0 clears select error
        if (ctrl_wr_i && !ctrl_wdata_i.port_enable_bit) begin
            stat_d.select_error_flag = 1'b0;
        end
        // setting wins over clearing below this line
        // done flag on each finished byte
        if (done_ev) begin
            stat_d.transfer_done_flag = 1'b1;
        end
        // collision flag only, transfer left alone
        if (collide) begin
            stat_d.write_collision_flag = 1'b1;
        end
        if (fault_ev) begin
            stat_d.mode_fault_flag = 1'b1;
        end
        if (sel_err) begin
            stat_d.select_error_flag = 1'b1;
        end
        stat_d.reserved = 4'h0;
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            stat_q      <= '0;
            arm_done_q  <= 1'b0;
            arm_coll_q  <= 1'b0;
            arm_fault_q <= 1'b0;
        end else begin
            stat_q      <= stat_d;
            arm_done_q  <= status_rd_i ? stat_q.transfer_done_flag
                         : (arm_done_q && !data_acc);
            arm_coll_q  <= status_rd_i ? stat_q.write_collision_flag
                         : (arm_coll_q && !data_acc);
            arm_fault_q <= status_rd_i ? stat_q.mode_fault_flag
                         : (arm_fault_q && !ctrl_wr_i);
        end
    end

    // ------------------------------------------------------------
    // receive buffer
    // ------------------------------------------------------------
    // keep the first byte while the done flag stands
    // later bytes simply vanish, nothing is flagged
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rbuf_q <= 8'h00;
        end else if (done_ev && !stat_q.transfer_done_flag) begin
            rbuf_q <= done_byte;
        end
    end

    // ------------------------------------------------------------
    // master sequencer and rate divider
    // ------------------------------------------------------------
    always_comb begin
        mst_d = mst_q;
        unique case (mst_q)
            M_IDLE: begin
                if (is_master && load) begin
                    mst_d = M_WAIT;
                end
            end
            // stall while the stream fifo has no room for the reply
            M_WAIT: begin
                if (fifo_ready) begin
                    mst_d = M_SHIFT;
                end
            end
            M_SHIFT: begin
                if (m_done) begin
                    mst_d = M_IDLE;
                end
            end
        endcase
        if (!is_master) begin
            mst_d = M_IDLE;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            mst_q  <= M_IDLE;
            div_q  <= '0;
            edge_q <= 4'h0;
            sck_q  <= 1'b0;
        end else begin
            mst_q <= mst_d;
            if (mst_q != M_SHIFT || tick) begin
                div_q <= '0;
            end else begin
                div_q <= div_q + DIV_ONE;
            end
            if (mst_q != M_SHIFT) begin
                edge_q <= 4'h0;
            end else if (tick) begin
                edge_q <= edge_q + 4'h1;
            end
            // clock rests at polarity, toggles on each tick
            if (mst_q != M_SHIFT) begin
                sck_q <= cpol;
            end else if (tick) begin
                sck_q <= !sck_q;
            end
        end
    end

    // ------------------------------------------------------------
    // shared shift engine
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !enabled) begin
            sh_q   <= 8'h00;
            out_q  <= 1'b0;
            bits_q <= 3'h0;
        end else begin
            if (load) begin
                sh_q  <= data_wdata_i;
                // msb ready before the first edge
                out_q <= data_wdata_i[7];
            end else if (samp_ev) begin
                // capture in msb first as the out bit moves
                sh_q <= rx_byte;
            end
            // drive edge presents the next bit, first one included with phase set
            if (drive_ev && !load) begin
                out_q <= sh_q[7];
            end
            // select fall with phase clear restarts the slave bit count
            if (is_slave && ss_fall && !cpha) begin
                bits_q <= 3'h0;
                out_q  <= sh_q[7];
            end else if (is_slave && ss_rise) begin
                bits_q <= 3'h0;
            end else if (slv_on && samp_ev) begin
                bits_q <= bits_q + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // pins and requests
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pin_out_q <= '0;
            pin_oe_q  <= '0;
            tx_irq_q  <= 1'b0;
            err_irq_q <= 1'b0;
        end else begin
            pin_out_q.sck  <= is_master ? sck_q : cpol;
            pin_out_q.mosi <= out_q;
            pin_out_q.miso <= out_q;
            pin_oe_q.sck   <= is_master;
            pin_oe_q.mosi  <= is_master;
            // miso released unless this slave is selected
            pin_oe_q.miso  <= slv_on;
            // done flag drives the transmit request
            tx_irq_q  <= stat_d.transfer_done_flag;
            // fault request only with select enabled
            err_irq_q <= stat_d.mode_fault_flag &&
                         !ctrl_d.select_disable_bit;
        end
    end

    // ------------------------------------------------------------
    // receive stream fifo
    // ------------------------------------------------------------
    // slave bytes arriving with the fifo full are lost to the stream
    byte_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (fifo_push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (done_byte),
        .out_valid_o (rx_valid_o),
        .out_ready_i (rx_ready_i),
        .out_data_o  (rx_data_o)
    );

    assign ctrl_o   = ctrl_q;
    assign status_o = stat_q;
    assign data_o   = rbuf_q;
    assign tx_irq_o = tx_irq_q;
    assign err_irq_o = err_irq_q;
    assign pin_o    = pin_out_q;
    assign pin_oe_o = pin_oe_q;

endmodule : spi_master_slave_port

`default_nettype wire

/* hdl/spi_port_pkg.sv */
// shared types and constants for the serial port block
package spi_port_pkg;

    // ------------------------------------------------------------
    // register layouts
    // ------------------------------------------------------------
    typedef struct packed {
        logic rate_sel_bit2;
        logic port_enable_bit;
        logic select_disable_bit;
        logic master_select_bit;
        logic clk_polarity;
        logic clk_phase;
        logic rate_sel_bit1;
        logic rate_sel_bit0;
    } port_control_t;

    typedef struct packed {
        logic       transfer_done_flag;
        logic       write_collision_flag;
        logic       select_error_flag;
        logic       mode_fault_flag;
        logic [3:0] reserved;
    } port_status_t;

    // serial pin group: input, output and enable per line
    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
    } pin_bits_t;

    // master engine states
    typedef enum logic [1:0] {
        M_IDLE,
        M_WAIT,
        M_SHIFT
    } master_state_t;

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET    = 8'h14;
    localparam int         BYTE_W        = 8;
    localparam int         FIFO_DEPTH    = 16;
    localparam int         DIV_W         = 7;
    localparam logic [2:0] RATE_NONE     = 3'h7;
    localparam logic [2:0] BIT_LAST      = 3'h7;
    localparam logic [3:0] EDGE_LAST     = 4'hf;
    localparam logic [6:0] DIV_ONE       = 7'h01;
    localparam int         CORE_CLK_HZ   = 20000000;

endpackage : spi_port_pkg

/* hdl/byte_fifo.sv */
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    // extra pointer bit tells full from empty
    assign in_ready_o  = !((wr_q[AW] != rd_q[AW]) &&
                           (wr_q[AW-1:0] == rd_q[AW-1:0]));
    assign out_valid_o = (wr_q != rd_q);
    assign out_data_o  = mem[rd_q[AW-1:0]];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

endmodule : byte_fifo

`default_nettype wire

/* testbench/spi_port_checker.sv */
// assertions on the serial port's own ports
`timescale 1ns/1ns
`default_nettype none
module spi_port_checker
    import spi_port_pkg::*;
(
    // clock, reset and processor side
    input wire logic                        core_clk_i,
    input wire logic                        rst_i,
    input wire logic                        ctrl_wr_i,
    input wire spi_port_pkg::port_control_t ctrl_wdata_i,
    input wire spi_port_pkg::port_control_t ctrl_o,
    input wire spi_port_pkg::port_status_t  status_o,
    input wire logic                        data_wr_i,
    input wire logic                        data_rd_i,
    // requests and pins
    input wire logic                        tx_irq_o,
    input wire logic                        err_irq_o,
    input wire spi_port_pkg::pin_bits_t     pin_oe_o,
    input wire logic                        ss_n_i
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    fault_set_a: assert property (
        (ctrl_o.port_enable_bit && ctrl_o.master_select_bit
         && !ctrl_o.select_disable_bit && !ss_n_i)[*3]
        |-> ##[0:3] status_o.mode_fault_flag)
        else $error("mode fault missed");
    fault_off_a: assert property (
        $rose(status_o.mode_fault_flag) |-> ##[0:1]
        !(ctrl_o.port_enable_bit || ctrl_o.master_select_bit))
        else $error("fault left port on");
    err_irq_a: assert property (
        err_irq_o == (status_o.mode_fault_flag && !ctrl_o.select_disable_bit))
        else $error("error request wrong");
    tx_irq_a: assert property (
        tx_irq_o == status_o.transfer_done_flag)
        else $error("done request wrong");
    done_clr_a: assert property (
        $fell(status_o.transfer_done_flag) |-> $past(data_rd_i)
        || $past(data_wr_i)) else $error("done lost");
    write_collision_flag_set_a: assert property (
        $rose(status_o.write_collision_flag) |-> $past(data_wr_i))
        else $error("collision without write");
    select_error_flag_clr_a: assert property (
        $fell(status_o.select_error_flag) |-> $past(ctrl_wr_i)
        && !$past(ctrl_wdata_i.port_enable_bit)) else $error("error lost");
    no_drive_a: assert property (
        (ss_n_i && !ctrl_o.master_select_bit
         && !ctrl_o.select_disable_bit)[*4] |-> !pin_oe_o.miso)
        else $error("unselected slave drives");
endmodule : spi_port_checker
`default_nettype wire

/* testbench/spi_slave_model.sv */
// behavioural serial slave facing the port in master role
`timescale 1ns/1ns
`default_nettype none
module spi_slave_model (
    // serial lines
    input wire logic       sck_i,
    input wire logic       mosi_i,
    input wire logic       sel_n_i,
    output logic           miso_o,
    // frame format and bytes
    input wire logic       cpol_i,
    input wire logic       cpha_i,
    input wire logic [7:0] tx_i,
    output logic [7:0]     rx_o,
    output int             nbytes_o
);
    logic [7:0] sh_q;
    logic       held_q;
    int         k;
    initial begin
        rx_o = 8'h00;
        nbytes_o = 0;
        held_q = 1'b0;
    end
    always @(negedge sel_n_i) begin
        sh_q = tx_i;
        k = 0;
    end
    always @(posedge sel_n_i) held_q = sh_q[7];
    // sample, shift; count wraps per byte
    always @(sck_i) if (!sel_n_i) begin
        if (sck_i == !(cpol_i ^ cpha_i)) begin
            rx_o = {rx_o[6:0], mosi_i};
            k = (k + 1) % 8;
            if (k == 0) nbytes_o++;
        end else if (k != 0) begin
            sh_q = sh_q << 1;
        end
    end
    // released line shows no stale bit
    assign miso_o = sel_n_i ? ~held_q : sh_q[7];
endmodule : spi_slave_model
`default_nettype wire

/* testbench/tb.sv */
// testbench: serial port in master and slave roles
`timescale 1ns/1ns
`default_nettype none
module tb;
    import spi_port_pkg::*;
    logic          core_clk_i, rst_i, ss_n_i, sel_n, bsck, miso;
    logic          ctrl_wr_i, status_rd_i, data_wr_i, data_rd_i;
    logic          tx_irq_o, err_irq_o, rx_valid_o, rx_ready_i;
    logic [7:0]    data_wdata_i, data_o, rx_data_o, mtx, mrx, q[$];
    port_control_t ctrl_wdata_i, ctrl_o;
    port_status_t  status_o;
    pin_bits_t     pin_i, pin_o, pin_oe_o;
    int            n_mismatch, n_tests, nb, i, k;
    assign pin_i = {pin_oe_o.sck ? pin_o.sck : bsck, pin_o.mosi, miso};
    spi_master_slave_port dut_u (.core_clk_i, .rst_i, .ctrl_wr_i,
        .ctrl_wdata_i, .ctrl_o, .status_rd_i, .status_o, .data_wr_i,
        .data_rd_i, .data_wdata_i, .data_o, .tx_irq_o, .err_irq_o,
        .rx_valid_o, .rx_ready_i, .rx_data_o, .pin_i, .pin_o,
        .pin_oe_o, .ss_n_i);
    spi_slave_model mdl_u (.sck_i(pin_o.sck), .mosi_i(pin_o.mosi),
        .sel_n_i(sel_n), .miso_o(miso), .cpol_i(ctrl_o.clk_polarity),
        .cpha_i(ctrl_o.clk_phase), .tx_i(mtx), .rx_o(mrx), .nbytes_o(nb));
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : tick
    // strobe w: 0 control write, 1 status read, 2 data write, 3 data read
    task automatic op(input int w, input logic [7:0] d);
        tick(1);
        ctrl_wdata_i <= port_control_t'(d);
        data_wdata_i <= d;
        {ctrl_wr_i, status_rd_i, data_wr_i, data_rd_i} <= 4'h8 >> w;
        tick(1);
        {ctrl_wr_i, status_rd_i, data_wr_i, data_rd_i} <= 4'h0;
    endtask : op
    task automatic clr();
        op(1, 8'h00);
        op(3, 8'h00);
        @(negedge core_clk_i);
    endtask : clr
    task automatic setss(input logic v, input int n);
        tick(1);
        ss_n_i <= v;
        tick(n);
        @(negedge core_clk_i);
    endtask : setss
    // select drops per byte, so leading-edge framing restarts
    task automatic xfer(input logic [7:0] s, m, input logic col);
        int n;
        tick(1);
        mtx <= m;
        sel_n <= 1'b0;
        n = nb;
        q.push_back(m);
        op(2, s);
        if (col) op(2, ~s);
        for (int j = 0; j < 400 && nb == n; j++) tick(1);
        tick(8);
        sel_n <= 1'b1;
        @(negedge core_clk_i);
        chk(mrx, s);
    endtask : xfer
    task automatic end_of_test();
        $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    initial begin
        tick(20000);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        rst_i = 1'b1;
        {ctrl_wr_i, status_rd_i, data_wr_i, data_rd_i} = 4'h0;
        ctrl_wdata_i = port_control_t'(8'h00);
        data_wdata_i = 8'h00;
        {rx_ready_i, ss_n_i, sel_n, bsck} = 4'b0110;
        mtx = 8'h00;
        n_mismatch = 0;
        n_tests = 0;
        tick(3);
        rst_i <= 1'b0;
        @(negedge core_clk_i);
        chk(ctrl_o, 8'h14);
        chk(status_o, 8'h00);
        for (i = 0; i < 4; i++) begin
            if (i > 0) op(0, 8'h32 | 8'((i - 1) << 2));
            op(0, 8'h32 | 8'(i << 2));
            op(0, 8'h72 | 8'(i << 2));
            xfer(8'h96 ^ 8'(i), 8'h3c + 8'(i), 1'b0);
            chk(data_o, 8'h3c + 8'(i));
            chk(tx_irq_o, 1'b1);
            chk(pin_o.sck, 8'(i >> 1));
            clr();
            chk(status_o, 8'h00);
        end
        xfer(8'h81, 8'he7, 1'b1);
        chk(status_o, 8'hc0);
        chk(err_irq_o, 1'b0);
        xfer(8'h18, 8'h7e, 1'b0);
        chk(data_o, 8'he7);
        chk(status_o, 8'hc0);
        clr();
        chk(status_o, 8'h00);
        // reader stalled: fill to sixteen, the next byte has to wait
        for (i = 0; i < 10; i++) xfer(8'(i), 8'(i + 16), 1'b0);
        tick(1);
        mtx <= 8'ha9;
        sel_n <= 1'b0;
        q.push_back(8'ha9);
        k = nb;
        op(2, 8'h5a);
        tick(300);
        chk(8'(nb - k), 8'h00);
        rx_ready_i <= 1'b1;
        for (i = 0; i < 600; i++) begin
            @(negedge core_clk_i);
            if (rx_valid_o === 1'b1 && q.size() > 0)
                chk(rx_data_o, q.pop_front());
        end
        chk(8'(q.size()), 8'h00);
        chk(mrx, 8'h5a);
        tick(1);
        sel_n <= 1'b1;
        clr();
        op(0, 8'h3e);
        op(0, 8'h12);
        op(0, 8'h52);
        setss(1'b0, 6);
        chk(status_o.mode_fault_flag, 1'b1);
        chk(ctrl_o, 8'h02);
        chk(err_irq_o, 1'b1);
        setss(1'b1, 3);
        op(1, 8'h00);
        op(0, 8'h32);
        op(0, 8'h72);
        @(negedge core_clk_i);
        chk(status_o.mode_fault_flag, 1'b0);
        setss(1'b0, 6);
        chk({status_o.mode_fault_flag, err_irq_o}, 8'h00);
        setss(1'b1, 1);
        op(0, 8'h40);
        setss(1'b1, 4);
        chk(pin_oe_o.miso, 1'b0);
        setss(1'b0, 4);
        chk(pin_oe_o.miso, 1'b1);
        for (i = 0; i < 6; i++) begin
            tick(4);
            bsck <= ~bsck;
        end
        setss(1'b1, 6);
        chk(status_o.select_error_flag, 1'b1);
        chk({tx_irq_o, err_irq_o}, 8'h00);
        op(0, 8'h00);
        @(negedge core_clk_i);
        chk(status_o.select_error_flag, 1'b0);
        end_of_test();
    end
endmodule : tb
bind spi_master_slave_port spi_port_checker chk_u (.core_clk_i, .rst_i,
    .ctrl_wr_i, .ctrl_wdata_i, .ctrl_o, .status_o, .data_wr_i, .data_rd_i,
    .tx_irq_o, .err_irq_o, .pin_oe_o, .ss_n_i);
`default_nettype wire
